// *** io_ports_interval_timer.v ***
// Two bidirectional ports, edge detect and interval timer
`timescale 1ns/1ps
`default_nettype none
`include "io_timer_defines.vh"

// Contract
// RL1 - Port A line is input when direction bit 0, output when 1
// RL2 - Port A output line drives its output register bit
// RL3 - Port A read returns the sampled pin levels
// RL4 - Output register writes stored always; pin follows only when output
// RL5 - Active edge on edge line sets edge flag regardless of enable
// RL6 - Edge flag with edge interrupt enabled pulls interrupt low
// RL7 - Edge control write takes polarity and enable from address, not data
// RL8 - Edge control: select high, addr4 low, addr2 high; a0 polarity, a1 enable
// RL9 - Reset disables edge interrupt and selects falling edge
// RL10 - Software clears edge flag before enabling edge interrupt
// RL11 - Reading the flag register clears the edge flag
// RL12 - Port B has its own direction and output registers, like port A
// RL13 - Port B read returns output register contents
// RL14 - Reset clears port registers, floats data bus, disables interrupts
// RL15 - System holds reset low at least one clock period
// RL16 - Read high, write low; data driven only on selected reads
// RL17 - Interrupt output active low open drain, from edge or timer
// RL18 - Timer write loads count and sets prescale from address bits
// RL19 - Prescale codes 00,01,10,11 give 1, 8, 64, 1024 clocks
// RL20 - Address bit 3 on any timer access sets timer interrupt enable
// RL21 - Before expiry timer read gives intervals remaining
// RL22 - After passing zero flag sets, count all ones, then every clock
// RL23 - Timer access clears flag unless it sets in same cycle
// RL24 - Flag read: timer flag bit 7, edge flag bit 6, rest zero
// RL25 - Port register select by address bits 1:0
module io_ports_interval_timer (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       chip_select_high,
    input  wire       chip_select_low_n,
    input  wire       register_select,
    input  wire       read_write,
    input  wire [4:0] addr,
    input  wire [7:0] data_in,
    output reg  [7:0] data_out,
    output reg        data_oe,
    input  wire [7:0] port_a_in,
    output reg  [7:0] port_a_out,
    output reg  [7:0] port_a_oe,
    input  wire [7:0] port_b_in,
    output reg  [7:0] port_b_out,
    output reg  [7:0] port_b_oe,
    output reg        irq_n_out,
    output reg        irq_n_oe
);
    // ======================================================
    // Register state
    reg  [7:0] port_a_output;
    reg  [7:0] port_a_direction;
    reg  [7:0] port_b_output;
    reg  [7:0] port_b_direction;
    reg  [7:0] interval_count;
    reg  [1:0] prescale_sel;
    reg        timer_irq_en;
    reg        timer_flag;
    reg        expired;
    reg        edge_flag;
    reg        edge_irq_en;
    reg        edge_polarity;
    reg  [7:0] pa_meta;
    reg  [7:0] pa_sync;
    reg  [7:0] pb_meta;
    reg  [7:0] pb_sync;
    reg        edge_prev;
    reg  [7:0] next_data;
    wire       interval_tick;

    // ======================================================
    // Access decode; bus sampled on the rising clock edge
    wire sel       = chip_select_high & ~chip_select_low_n & register_select;
    wire rd        = sel & read_write;                      // see RL16
    wire wr        = sel & ~read_write;                     // see RL16
    wire timer_sel = addr[`ADDR_TIMER_SEL_BIT];
    wire port_wr   = wr & ~timer_sel;
    wire timer_wr  = wr & timer_sel & addr[`ADDR_TIMER_WR_BIT];   // see RL18
    wire edge_wr   = wr & timer_sel & ~addr[`ADDR_TIMER_WR_BIT];  // see RL8
    wire timer_rd  = rd & timer_sel & ~addr[`ADDR_POLARITY_BIT];
    wire flag_rd   = rd & timer_sel & addr[`ADDR_POLARITY_BIT];
    wire timer_acc = timer_wr | timer_rd;

    // ======================================================
    // Two-flop synchronisers on the peripheral pins.
    // Port A resets to the pulled-up idle level: no false edge after reset.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pa_meta <= `PIN_IDLE_RESET;
            pa_sync <= `PIN_IDLE_RESET;
            pb_meta <= 8'h00;
            pb_sync <= 8'h00;
        end else begin
            pa_meta <= port_a_in;
            pa_sync <= pa_meta;
            pb_meta <= port_b_in;
            pb_sync <= pb_meta;
        end
    end

    // ======================================================
    // Port registers; writes land regardless of direction
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_output    <= `PORT_RESET;               // see RL14
            port_a_direction <= `PORT_RESET;
            port_b_output    <= `PORT_RESET;
            port_b_direction <= `PORT_RESET;
        end else if (port_wr) begin
            case (addr[1:0])                                 // see RL25
                `PORT_A_OUTPUT_SEL:    port_a_output <= data_in; // see RL4
                `PORT_A_DIRECTION_SEL: port_a_direction <= data_in;
                `PORT_B_OUTPUT_SEL:    port_b_output <= data_in; // see RL12
                default:               port_b_direction <= data_in;
            endcase
        end
    end

    // ======================================================
    // Pin drive, registered so outputs come from flops
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_out <= 8'h00;
            port_a_oe  <= 8'h00;
            port_b_out <= 8'h00;
            port_b_oe  <= 8'h00;
        end else begin
            port_a_out <= port_a_output;                     // see RL2
            port_a_oe  <= port_a_direction;                  // see RL1
            port_b_out <= port_b_output;                     // see RL12
            port_b_oe  <= port_b_direction;
        end
    end

    // ======================================================
    // Edge control: address carries the settings, data ignored
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_irq_en   <= 1'b0;                           // see RL9
            edge_polarity <= `EDGE_POL_RESET;                // see RL9
        end else if (edge_wr) begin
            edge_polarity <= addr[`ADDR_POLARITY_BIT];       // see RL7
            edge_irq_en   <= addr[`ADDR_EDGE_EN_BIT];        // see RL7
        end
    end

    // ======================================================
    // Edge detect on the synchronised line, any direction.
    // Edge sampled from the pin, so driven outputs also count.
    wire edge_line = pa_sync[7];
    wire edge_hit  = edge_polarity ? (edge_line & ~edge_prev)
                                   : (~edge_line & edge_prev);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_prev <= 1'b1;
            edge_flag <= 1'b0;
        end else begin
            edge_prev <= edge_line;
            if (edge_hit)
                edge_flag <= 1'b1;                           // see RL5
            else if (flag_rd)
                edge_flag <= 1'b0;                           // see RL11
        end
    end

    // ======================================================
    // Prescaler restarted on every timer load
    prescale_divider u_prescale (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .restart (timer_wr),
        .select  (prescale_sel),
        .tick    (interval_tick)
    );

    // ======================================================
    // Interval counter; after expiry it runs every clock.
    // Underflow from zero is the expiry moment.
    wire count_step = expired | interval_tick;               // see RL22
    wire expire_now = count_step & ~expired
                    & (interval_count == 8'h00);
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            interval_count <= 8'h00;
            prescale_sel   <= `PRESCALE_DIV1;
            timer_irq_en   <= 1'b0;                          // see RL14
            expired        <= 1'b0;
        end else begin
            if (timer_acc)
                timer_irq_en <= addr[`ADDR_TIMER_EN_BIT];    // see RL20
            if (timer_wr) begin
                interval_count <= data_in;                   // see RL18
                prescale_sel   <= addr[1:0];                 // see RL19
                expired        <= 1'b0;
            end else if (count_step) begin
                interval_count <= interval_count - 8'h01;    // see RL21
                if (expire_now)
                    expired <= 1'b1;                         // see RL22
            end
        end
    end

    // Flag: setting wins over a same-cycle timer read; a same-cycle timer load blocks it
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            timer_flag <= 1'b0;
        else if (expire_now & ~timer_wr)
            timer_flag <= 1'b1;                              // see RL22
        else if (timer_acc)
            timer_flag <= 1'b0;                              // see RL23
    end

    // ======================================================
    // Read data mux
    always @* begin
        next_data = 8'h00;
        if (timer_sel) begin
            if (addr[`ADDR_POLARITY_BIT]) begin
                next_data[`TIMER_FLAG_BIT] = timer_flag;     // see RL24
                next_data[`EDGE_FLAG_BIT]  = edge_flag;      // see RL24
            end else begin
                next_data = interval_count;                  // see RL21
            end
        end else begin
            case (addr[1:0])
                `PORT_A_OUTPUT_SEL:    next_data = pa_sync;  // see RL3
                `PORT_A_DIRECTION_SEL: next_data = port_a_direction;
                `PORT_B_OUTPUT_SEL:    next_data = port_b_output; // see RL13
                default:               next_data = port_b_direction;
            endcase
        end
    end

    // Data bus driven for one cycle after a selected read
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;                                // see RL14
        end else begin
            data_out <= rd ? next_data : 8'h00;
            data_oe  <= rd;                                  // see RL16
        end
    end

    // ======================================================
    // Open-drain interrupt: output always low, enable pulls.
    // Edge flag is only gated here; it is set regardless (RL10 hazard).
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= 1'b0;
        end else begin
            irq_n_out <= 1'b0;
            irq_n_oe  <= (edge_flag & edge_irq_en)           // see RL6
                       | (timer_flag & timer_irq_en);        // see RL17
        end
    end
endmodule // io_ports_interval_timer
`default_nettype wire

// *** io_timer_defines.vh ***
// Constants for the port and interval timer block
`ifndef IO_TIMER_DEFINES_VH
`define IO_TIMER_DEFINES_VH
// ==========================================================
// Register select codes within the port section (addr 1:0)
`define PORT_A_OUTPUT_SEL    2'h0
`define PORT_A_DIRECTION_SEL 2'h1
`define PORT_B_OUTPUT_SEL    2'h2
`define PORT_B_DIRECTION_SEL 2'h3
// ==========================================================
// Address bit positions
`define ADDR_POLARITY_BIT  0
`define ADDR_EDGE_EN_BIT   1
`define ADDR_TIMER_SEL_BIT 2
`define ADDR_TIMER_EN_BIT  3
`define ADDR_TIMER_WR_BIT  4
// ==========================================================
// Flag register field positions
`define TIMER_FLAG_BIT 7
`define EDGE_FLAG_BIT  6
// ==========================================================
// Reset values
`define PORT_RESET     8'h00
`define EDGE_POL_RESET 1'b0
// Port lines idle high through their pull-ups
`define PIN_IDLE_RESET 8'hff
// ==========================================================
// Prescale codes and divider width (1, 8, 64, 1024 clocks)
`define PRESCALE_DIV1    2'h0
`define PRESCALE_DIV8    2'h1
`define PRESCALE_DIV64   2'h2
`define PRESCALE_DIV1024 2'h3
`define PRESCALE_WIDTH   10
// Last divider count of each interval (length minus one)
`define PRESCALE_LAST1    10'h000
`define PRESCALE_LAST8    10'h007
`define PRESCALE_LAST64   10'h03f
`define PRESCALE_LAST1024 10'h3ff
`endif

// *** prescale_divider.v ***
// Prescale divider producing one-cycle interval enable pulses
`timescale 1ns/1ps
`default_nettype none
`include "io_timer_defines.vh"

module prescale_divider (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       restart,
    input  wire [1:0] select,
    output reg        tick
);
    // ======================================================
    // Interval length minus one for each prescale code
    function [9:0] last_count;
        input [1:0] code;
        begin
            case (code)
                `PRESCALE_DIV1:  last_count = `PRESCALE_LAST1;
                `PRESCALE_DIV8:  last_count = `PRESCALE_LAST8;
                `PRESCALE_DIV64: last_count = `PRESCALE_LAST64;
                default:         last_count = `PRESCALE_LAST1024;
            endcase
        end
    endfunction

    reg [`PRESCALE_WIDTH-1:0] count;

    // Restart aligns the first interval with the load
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 10'h000;
            tick  <= 1'b0;
        end else if (restart) begin
            count <= 10'h000;
            tick  <= 1'b0;
        end else if (count == last_count(select)) begin
            count <= 10'h000;
            tick  <= 1'b1;
        end else begin
            count <= count + 10'h001;
            tick  <= 1'b0;
        end
    end
endmodule // prescale_divider
`default_nettype wire

// *** io_ports_interval_timer_asserts.sv ***
// Checker on the port and interval timer block ports
`timescale 1ns/1ps
`default_nettype none
module io_ports_interval_timer_asserts (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       chip_select_high,
    input wire logic       chip_select_low_n,
    input wire logic       register_select,
    input wire logic       read_write,
    input wire logic [4:0] addr,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe,
    input wire logic [7:0] port_b_out,
    input wire logic [7:0] port_b_oe,
    input wire logic       irq_n_out,
    input wire logic       irq_n_oe
);
    // ==========
    // Access decode, one clock domain
    wire sel = chip_select_high & ~chip_select_low_n & register_select;
    wire rd  = sel & read_write;
    wire pw  = sel & ~read_write & ~addr[2];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Bus answers
    property p_rd; rd |=> data_oe; endproperty
    a_rd: assert property (p_rd) else $error("no read drive");
    property p_idle; !rd |=> !data_oe; endproperty
    a_idle: assert property (p_idle) else $error("stray drive");
    property p_flg; rd && addr[2] && addr[0] |=> data_out[5:0] == 6'h00;
    endproperty
    a_flg: assert property (p_flg) else $error("flag pad");
    property p_pbr; rd && addr[2:0] == 3'h2 |=> data_out == port_b_out;
    endproperty
    a_pbr: assert property (p_pbr) else $error("port b read");
    // Open drain: only ever pulls low
    property p_irq; !irq_n_out; endproperty
    a_irq: assert property (p_irq) else $error("irq level");
    // ==========
    // Port writes show on the pin copies two edges later
    property p_dira; pw && addr[1:0] == 2'h1 |->
        ##2 port_a_oe == $past(data_in, 2); endproperty
    a_dira: assert property (p_dira) else $error("dir a");
    property p_outa; pw && addr[1:0] == 2'h0 |->
        ##2 port_a_out == $past(data_in, 2); endproperty
    a_outa: assert property (p_outa) else $error("out a");
    property p_outb; pw && addr[1:0] == 2'h2 |->
        ##2 port_b_out == $past(data_in, 2); endproperty
    a_outb: assert property (p_outb) else $error("out b");
    property p_dirb; pw && addr[1:0] == 2'h3 |->
        ##2 port_b_oe == $past(data_in, 2); endproperty
    a_dirb: assert property (p_dirb) else $error("dir b");
    // Main scenarios reached
    c_tmr: cover property (sel && !read_write && addr[4] && addr[2]);
    c_edge: cover property (sel && !read_write && !addr[4] && addr[2]);
    c_tflag: cover property (rd && addr[2] && addr[0] ##1 data_out[7]);
endmodule // io_ports_interval_timer_asserts
`default_nettype wire

// *** bus_master_model.sv ***
// Processor bus master model for the register bus
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_out,
    output var  logic       chip_select_high = 1'b0,
    output var  logic       chip_select_low_n = 1'b1,
    output var  logic       register_select = 1'b0,
    output var  logic       read_write = 1'b1,
    output var  logic [4:0] addr = 5'h00,
    output var  logic [7:0] data_in = 8'h00
);
    // One access, held from launch edge to the taking edge
    task automatic acc(input logic rw, input logic [4:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        chip_select_high <= 1'b1;
        chip_select_low_n <= 1'b0;
        register_select <= 1'b1;
        read_write <= rw;
        addr <= a;
        data_in <= rw ? ~data_in : d;
        @(posedge ref_clk);
        // Released data shows the inverse so stale values never match
        chip_select_high <= 1'b0;
        chip_select_low_n <= 1'b1;
        data_in <= ~data_in;
        @(negedge ref_clk);
        q = data_out;
    endtask
endmodule // bus_master_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the port and interval timer block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========
    // Stimulus, pins and bus
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] pa_ext = 8'hff;
    logic [7:0] pb_ext = 8'h5a;
    logic [7:0] q, d, n;
    logic [7:0] mdl [4] = '{default: 8'h00};
    wire        cs_h, cs_l_n, rs, rw, data_oe, irq_n_out, irq_n_oe;
    wire  [4:0] addr;
    wire  [7:0] data_in, data_out, pa_out, pa_oe, pb_out, pb_oe;
    int         err_count, checks, seed, cyc, t0, e, p;
    // Undriven lines follow the peripheral side
    wire  [7:0] pa_pin = (pa_oe & pa_out) | (~pa_oe & pa_ext);
    wire  [7:0] pb_pin = (pb_oe & pb_out) | (~pb_oe & pb_ext);
    io_ports_interval_timer u_io_ports_interval_timer (
        .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_high(cs_h),
        .chip_select_low_n(cs_l_n), .register_select(rs),
        .read_write(rw), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .port_a_in(pa_pin),
        .port_a_out(pa_out), .port_a_oe(pa_oe), .port_b_in(pb_pin),
        .port_b_out(pb_out), .port_b_oe(pb_oe), .irq_n_out(irq_n_out),
        .irq_n_oe(irq_n_oe));
    bus_master_model u_bus_master_model (
        .ref_clk(ref_clk), .data_out(data_out), .chip_select_high(cs_h),
        .chip_select_low_n(cs_l_n), .register_select(rs),
        .read_write(rw), .addr(addr), .data_in(data_in));
    // Clock and cycle count
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    // ==========
    // Helpers
    task automatic chk(input string nm, input logic [7:0] x,
                       input logic [7:0] y);
        checks++;
        if (y !== x) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, y);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        u_bus_master_model.acc(1'b0, a, v, q);
    endtask
    task automatic rd(input logic [4:0] a);
        u_bus_master_model.acc(1'b1, a, 8'h00, q);
    endtask
    function automatic logic [7:0] pin(input logic [7:0] dr, o, x);
        return (dr & o) | (~dr & x);
    endfunction
    function automatic int pdiv(input int k);
        return (k == 3) ? 1024 : (1 << (3 * k));
    endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        seed = 32'h23bdeaf9;
        repeat (8) @(posedge ref_clk);
        chk("oe_rst", 8'h00, {pa_oe | pb_oe});
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            rd(5'(i));
            chk("port_rst", (i == 0) ? pa_ext : 8'h00, q);
        end
        // Default edge setup: falling edge, request off
        @(posedge ref_clk) pa_ext <= 8'h7f;
        repeat (6) @(posedge ref_clk);
        chk("irq_dflt", 8'h00, {7'h00, irq_n_oe});
        rd(5'h05);
        chk("flag_dflt", 8'h40, q & 8'h7f);
        $display("test reset done");
        repeat (16) begin
            p = $random(seed) & 3;
            d = 8'($random(seed));
            wr(5'(p), d);
            mdl[p] = d;
            @(posedge ref_clk) pa_ext <= 8'($random(seed));
            pb_ext <= 8'($random(seed));
            repeat (4) @(posedge ref_clk);
            chk("pa_pin", pin(mdl[1], mdl[0], pa_ext), pa_pin);
            chk("pb_pin", pin(mdl[3], mdl[2], pb_ext), pb_pin);
            for (int i = 0; i < 4; i++) begin
                rd(5'(i));
                d = i ? mdl[i] : pin(mdl[1], mdl[0], pa_ext);
                chk("port_rd", d, q);
            end
        end
        $display("test ports done");
        wr(5'h01, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr({3'b001, 2'(c)}, 8'($random(seed)));
            @(posedge ref_clk) pa_ext[7] <= ~c[0];
            repeat (6) @(posedge ref_clk);
            rd(5'h05);
            @(posedge ref_clk) pa_ext[7] <= c[0];
            repeat (6) @(posedge ref_clk);
            chk("irq_edge", {7'h00, c[1]}, {7'h00, irq_n_oe});
            rd(5'h05);
            chk("edge_set", 8'h40, q & 8'h7f);
            rd(5'h05);
            chk("edge_clr", 8'h00, q & 8'h7f);
            @(posedge ref_clk) pa_ext[7] <= ~c[0];
            repeat (6) @(posedge ref_clk);
            rd(5'h05);
            chk("edge_quiet", 8'h00, q & 8'h7f);
        end
        wr(5'h04, 8'h00);
        $display("test edge done");
        for (int k = 0; k < 4; k++) begin
            n = 8'(2 + ($random(seed) & 3));
            p = pdiv(k);
            wr({3'b111, 2'(k)}, n);
            t0 = cyc;
            if (k > 1) begin
                rd(5'h0c);
                checks++;
                if (q !== n && q !== n - 8'h01) begin
                    err_count++;
                    $display("[FAIL] early_count expected %h seen %h", n, q);
                end
            end
            e = 0;
            do begin rd(5'h05); e++; end while (q[7] !== 1'b1 && e < 4000);
            e = cyc - t0;
            checks++;
            if (e < int'(n) * p || e > (int'(n) + 1) * p + 5) begin
                err_count++;
                $display("[FAIL] expiry expected %0d seen %0d", n * p, e);
            end
            chk("tflag", 8'h80, q);
            chk("irq_tmr", 8'h01, {7'h00, irq_n_oe});
            repeat (32) @(posedge ref_clk);
            rd(5'h04);
            chk("free_run", 8'h06, {5'h00, q[7:5]});
            rd(5'h05);
            chk("tflag_clr", 8'h00, q);
            chk("irq_off", 8'h00, {7'h00, irq_n_oe});
        end
        // Timer load with its interrupt disabled: flag sets, no request
        wr(5'h14, 8'h01);
        repeat (8) @(posedge ref_clk);
        rd(5'h05);
        chk("tflag_quiet", 8'h80, q);
        chk("irq_quiet", 8'h00, {7'h00, irq_n_oe});
        $display("test timer done");
        wr(5'h01, 8'hff);
        @(posedge ref_clk) rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("oe_rst2", 8'h00, pa_oe);
        rst_n <= 1'b1;
        rd(5'h01);
        chk("dir_rst2", 8'h00, q);
        $display("test midreset done");
        results();
    end
    // Watchdog well beyond the longest timer run
    initial begin
        #600000;
        err_count++;
        results();
    end
endmodule // tb_top
bind io_ports_interval_timer io_ports_interval_timer_asserts u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .chip_select_high(chip_select_high),
    .chip_select_low_n(chip_select_low_n), .register_select(register_select),
    .read_write(read_write), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
`default_nettype wire
